//--- dv/osc_host_model.sv
// Host-side model that drives the three-wire programming port of the oscillator
`timescale 1ns/1ns
`default_nettype none
module osc_host_model (
  output logic serial_data_in,
  output logic serial_clk,
  output logic port_enable_n
);
  // ---------------------------------------------------------------
  // Idle state: clock parked low, enable high
  // ---------------------------------------------------------------
  initial begin
    serial_data_in = 1'b1;
    serial_clk     = 1'b0;
    port_enable_n  = 1'b1;
  end

  // ---------------------------------------------------------------
  // Frame sender
  // ---------------------------------------------------------------
  // Sends nbits clocks of word w; extra ns stretch each high phase, twice extra each low phase
  task automatic send(input logic [15:0] w, input int nbits, input int extra);
    logic b;
    b             = 1'b0;
    port_enable_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      b = (i < 16) ? w[15 - i] : 1'b0;
      #(7 + extra) serial_data_in = b;
      #(193 + extra) serial_clk = 1'b1;
      #(200 + extra) serial_clk = 1'b0;
    end
    // Released data line must not keep showing the last bit
    #20 serial_data_in = ~b;
    #180 port_enable_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_osc_serial_program_port.sv
// Self-checking bench for the oscillator serial programming port
`timescale 1ns/1ns
`default_nettype none
`include "osc_serial_regs.svh"
module tb_osc_serial_program_port;
  localparam logic [5:0] ABASE = 6'h15;
  typedef struct {
    logic [15:0] word;
    logic        main_run;
    logic        aux_run;
  } row_t;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        serial_data_in;
  logic        serial_clk;
  logic        port_enable_n;
  logic        addr_strap;
  logic        output_gate;
  logic        main_clk;
  logic        aux_clk;
  logic [3:0]  range_divider_code;
  logic [9:0]  fine_tune_code;
  logic        output_config_hi;
  logic        output_config_lo;
  logic [6:0]  bus_address;
  logic [31:0] rd;
  logic        mt;
  logic        at;
  logic        same;
  int          bad_count;
  int          cmp_count;
  row_t        rows [4];

  // ---------------------------------------------------------------
  // Design, host model and clock
  // ---------------------------------------------------------------
  osc_serial_program_port #(.ADDR_BASE(ABASE), .DIV_SHIFT(20)) osc_serial_program_port_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_data_in(serial_data_in), .serial_clk(serial_clk),
    .port_enable_n(port_enable_n), .addr_strap(addr_strap), .output_gate(output_gate),
    .main_clk(main_clk), .aux_clk(aux_clk), .range_divider_code(range_divider_code),
    .fine_tune_code(fine_tune_code), .output_config_hi(output_config_hi),
    .output_config_lo(output_config_lo), .bus_address(bus_address));
  osc_host_model osc_host_model_i (
    .serial_data_in(serial_data_in), .serial_clk(serial_clk),
    .port_enable_n(port_enable_n));
  always #25 hclk = ~hclk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      bad_count++;
    end
  endtask

  // One single AHB transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
        bad_count++;
        summarize();
      end
      if (p == 0) begin
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rdv = hrdata;
    chk(hresp, 32'h0, "bus response");
  endtask

  // Watches both outputs for 40 cycles: toggled flags and equal-level flag
  task automatic watch(output logic m, output logic a, output logic s);
    logic pm;
    logic pa;
    m = 1'b0;
    a = 1'b0;
    s = 1'b0;
    @(negedge hclk);
    pm = main_clk;
    pa = aux_clk;
    repeat (40) begin
      @(negedge hclk);
      if (main_clk !== pm) m = 1'b1;
      if (aux_clk !== pa) a = 1'b1;
      if (main_clk === aux_clk) s = 1'b1;
      pm = main_clk;
      pa = aux_clk;
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; addr_strap = 1'b0; output_gate = 1'b1;
    bad_count = 0; cmp_count = 0;
    rows = '{'{16'hf000, 1'b1, 1'b1}, '{16'hfffd, 1'b0, 1'b1},
             '{16'ha556, 1'b1, 1'b0}, '{16'h0003, 1'b0, 1'b0}};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    // Reset values and an unmapped address
    chk({range_divider_code, fine_tune_code, output_config_hi, output_config_lo}, 0, "rst");
    ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, 32'h0, "setting reset");
    ahb(1'b0, `OFS_CTRL, 32'h0, rd); chk(rd, 32'h1, "ctrl reset");
    ahb(1'b0, `OFS_STATUS, 32'h0, rd); chk({24'h0, rd[7:0]}, 32'h0, "status reset");
    ahb(1'b0, 8'h10, 32'h0, rd); chk(rd, 32'h0, "unmapped read");
    $display("reset test done");
    // Table of good frames: every output configuration code
    for (int r = 0; r < 4; r++) begin
      osc_host_model_i.send(rows[r].word, 16, 0);
      chk({range_divider_code, fine_tune_code, output_config_hi, output_config_lo},
          {16'h0, rows[r].word}, "fields");
      ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, {16'h0, rows[r].word}, "setting");
      watch(mt, at, same);
      chk({mt, at, main_clk & ~rows[r].main_run, aux_clk & ~rows[r].aux_run},
          {rows[r].main_run, rows[r].aux_run, 2'b00}, "activity");
      if (rows[r].word[1:0] == 2'h0) chk(same, 1'b0, "complement");
      $display("row %0d done", r);
    end
    // Short and long frames are refused
    osc_host_model_i.send(16'h1234, 15, 0);
    ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, 32'h3, "short frame");
    ahb(1'b0, `OFS_STATUS, 32'h0, rd); chk(rd[6], 1'b1, "short error");
    ahb(1'b1, `OFS_STATUS, 32'h40, rd);
    ahb(1'b0, `OFS_STATUS, 32'h0, rd); chk(rd[6], 1'b0, "error clear");
    osc_host_model_i.send(16'h5678, 17, 0);
    ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, 32'h3, "long frame");
    ahb(1'b0, `OFS_STATUS, 32'h0, rd); chk(rd[6], 1'b1, "long error");
    // Port switched off by software: a good frame is not taken
    ahb(1'b1, `OFS_CTRL, 32'h0, rd);
    osc_host_model_i.send(16'h5678, 16, 0);
    ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, 32'h3, "port disabled");
    ahb(1'b1, `OFS_CTRL, 32'h1, rd);
    $display("bad frame test done");
    // Slow host, then commit count
    osc_host_model_i.send(16'hf000, 16, 300);
    ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, 32'hf000, "slow frame");
    ahb(1'b0, `OFS_COMMITS, 32'h0, rd); chk(rd, 32'h5, "commits");
    watch(mt, at, same); chk({30'h0, mt, at}, 32'h0, "waking quiet");
    $display("slow frame test done");
    // Gate forces both outputs low at once
    repeat (2100) @(posedge hclk);
    watch(mt, at, same); chk({30'h0, mt, at}, 32'h3, "running again");
    @(posedge hclk);
    output_gate <= 1'b0;
    #2 chk({main_clk, aux_clk}, 32'h0, "gate");
    watch(mt, at, same);
    chk({mt, at, main_clk, aux_clk}, 32'h0, "gated");
    @(posedge hclk);
    output_gate <= 1'b1;
    $display("gate test done");
    // Strap selects the low address bit
    @(posedge hclk);
    addr_strap <= 1'b1;
    repeat (4) @(posedge hclk);
    #1 chk(bus_address, {ABASE, 1'b1}, "strap");
    ahb(1'b0, `OFS_STATUS, 32'h0, rd); chk(rd[14:8], {ABASE, 1'b1}, "status addr");
    $display("strap test done");
    // Reset in mid-run clears the setting
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({range_divider_code, fine_tune_code, output_config_hi, output_config_lo,
         main_clk, aux_clk}, 32'h0, "mid reset");
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, `OFS_SETTING, 32'h0, rd); chk(rd, 32'h0, "setting after reset");
    ahb(1'b0, `OFS_STATUS, 32'h0, rd); chk({24'h0, rd[7:0]}, 32'h0, "status after rst");
    $display("mid reset test done");
    summarize();
  end
endmodule
`default_nettype wire

//--- rtl/osc_serial_pkg.sv
// Types shared by the oscillator serial programming port
package osc_serial_pkg;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SHIFT
  } port_state_t;
endpackage

//--- rtl/osc_serial_program_port.sv
// Serial programming port, output generator and AHB-Lite registers of the oscillator
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "osc_serial_regs.svh"
module osc_serial_program_port #(
  parameter logic [5:0] ADDR_BASE = 6'h2a, // Arbitrary upper bus address bits
  parameter int         DIV_SHIFT = 11
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_data_in,
  input  wire logic        serial_clk,
  input  wire logic        port_enable_n,
  input  wire logic        addr_strap,
  input  wire logic        output_gate,
  output logic             main_clk,
  output logic             aux_clk,
  output logic      [3:0]  range_divider_code,
  output logic      [9:0]  fine_tune_code,
  output logic             output_config_hi,
  output logic             output_config_lo,
  output logic      [6:0]  bus_address
);
  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sdi_s, sclk_s, sen_n_s, strap_s;
  logic       sclk_prev_q, sen_n_prev_q;
  logic       sclk_rise, sen_fall, sen_rise;

  pin_sync #(.WIDTH(4)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({serial_data_in, serial_clk, ~port_enable_n, addr_strap}), // Enable inverted
    .pin_out (pins_s)
  );

  // Zero reset of the flops reads as an idle high enable: no false edge
  assign {sdi_s, sclk_s, sen_n_s, strap_s} = {pins_s[3:2], ~pins_s[1], pins_s[0]};
  // Edge history of the synchronised serial clock and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev_q  <= 1'b0;
      sen_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q  <= sclk_s;
      sen_n_prev_q <= sen_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sen_fall  = ~sen_n_s & sen_n_prev_q;
  assign sen_rise  = sen_n_s & ~sen_n_prev_q;

  // -----------------------------------------------------------------
  // Serial receive engine
  // -----------------------------------------------------------------
  osc_serial_pkg::port_state_t state_q;
  logic [15:0] shift_q;
  logic [4:0]  bit_cnt_q;
  logic [15:0] setting_q;
  logic [15:0] commit_cnt_q;
  logic        ctrl_en_q;
  logic        frame_err_q;
  logic        commit;
  logic        frame_bad;
  logic        err_clr;

  assign commit    = (state_q == osc_serial_pkg::ST_SHIFT) && sen_rise
                     && (bit_cnt_q == `WORD_BITS) && ctrl_en_q;
  assign frame_bad = (state_q == osc_serial_pkg::ST_SHIFT) && sen_rise
                     && (bit_cnt_q != `WORD_BITS);

  // Transaction state: opened by enable falling, closed by enable rising
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= osc_serial_pkg::ST_IDLE;
    end else begin
      case (state_q)
        osc_serial_pkg::ST_IDLE: begin
          if (sen_fall && ctrl_en_q) begin
            state_q <= osc_serial_pkg::ST_SHIFT;
          end
        end
        osc_serial_pkg::ST_SHIFT: begin
          if (sen_rise) begin
            state_q <= osc_serial_pkg::ST_IDLE;
          end
        end
        default: state_q <= osc_serial_pkg::ST_IDLE;
      endcase
    end
  end

  // Shift register and bit counter, MSB first from the data pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q   <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else if (sen_fall) begin
      bit_cnt_q <= 5'h00;
    end else if (state_q == osc_serial_pkg::ST_SHIFT && sclk_rise) begin
      shift_q <= {shift_q[14:0], sdi_s};
      if (bit_cnt_q != `CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Committed setting; only a well-formed frame reaches it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setting_q    <= `SETTING_RESET;
      commit_cnt_q <= 16'h0000;
    end else if (commit) begin
      setting_q <= shift_q;
      if (commit_cnt_q != 16'hffff) begin
        commit_cnt_q <= commit_cnt_q + 16'h0001;
      end
    end
  end

  // Frame error flag: a new error wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_err_q <= 1'b0;
    end else if (frame_bad) begin
      frame_err_q <= 1'b1;
    end else if (err_clr) begin
      frame_err_q <= 1'b0;
    end
  end

  // Setting fields
  assign range_divider_code = setting_q[`OCT_HI:`OCT_LO];
  assign fine_tune_code     = setting_q[`DAC_HI:`DAC_LO];
  assign output_config_hi   = setting_q[`CNF_HI_BIT];
  assign output_config_lo   = setting_q[`CNF_LO_BIT];

  // -----------------------------------------------------------------
  // Strap-selected bus address
  // -----------------------------------------------------------------
  logic [6:0] bus_addr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_addr_q <= 7'h00;
    end else begin
      bus_addr_q <= {ADDR_BASE, strap_s};
    end
  end

  assign bus_address = bus_addr_q;

  // -----------------------------------------------------------------
  // Output frequency generator
  // -----------------------------------------------------------------
  logic [1:0]  cfg;
  logic [11:0] span_base;
  logic [26:0] span;
  logic [26:0] reload;
  logic [26:0] half_cnt_q;
  logic        phase_q;
  logic [11:0] wake_cnt_q;
  logic        waking;

  assign cfg       = {output_config_hi, output_config_lo};
  assign span_base = `FULL_SCALE - {2'b00, fine_tune_code};
  assign span      = {15'h0000, span_base} << (`OCT_MAX - {1'b0, range_divider_code});
  assign reload    = ((span >> DIV_SHIFT) == 27'h0) ? 27'h1 : (span >> DIV_SHIFT);
  assign waking    = (wake_cnt_q != 12'h000);

  // Half-period counter sets the square wave rate from the setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_q <= 27'h0;
      phase_q    <= 1'b0;
    end else if (half_cnt_q == 27'h0) begin
      half_cnt_q <= reload - 27'h1;
      phase_q    <= ~phase_q;
    end else begin
      half_cnt_q <= half_cnt_q - 27'h1;
    end
  end

  // Recovery time after leaving shutdown keeps outputs quiet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt_q <= 12'h000;
    end else if (cfg == `CFG_SHUTDOWN) begin
      wake_cnt_q <= 12'(`WAKE_CYCLES);
    end else if (waking) begin
      wake_cnt_q <= wake_cnt_q - 12'h001;
    end
  end

  // Output pins; the gate clears them without waiting for a clock
  always_ff @(posedge hclk or negedge hresetn or negedge output_gate) begin
    if (!hresetn) begin
      main_clk <= 1'b0;
      aux_clk  <= 1'b0;
    end else if (!output_gate) begin
      main_clk <= 1'b0;
      aux_clk  <= 1'b0;
    end else if (cfg == `CFG_SHUTDOWN || waking) begin
      main_clk <= 1'b0;
      aux_clk  <= 1'b0;
    end else begin
      main_clk <= phase_q & (cfg != `CFG_AUX_ONLY);
      aux_clk  <= (cfg == `CFG_AUX_ONLY) ? phase_q
                : (cfg == `CFG_MAIN_ONLY) ? 1'b0 : ~phase_q;
    end
  end

  // -----------------------------------------------------------------
  // AHB-Lite register slave, zero wait states
  // -----------------------------------------------------------------
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       addr_ok;

  assign addr_ok = hsel && htrans[1] && hready;
  assign err_clr = wr_pend_q && (wr_addr_q == `OFS_STATUS) && hwdata[`ST_FRAME_ERR];

  // Address phase capture; read data is ready for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
      if (addr_ok && !hwrite) begin
        if (haddr == `OFS_CTRL) begin
          hrdata <= {31'h0, ctrl_en_q};
        end else if (haddr == `OFS_SETTING) begin
          hrdata <= {16'h0000, setting_q};
        end else if (haddr == `OFS_STATUS) begin
          hrdata <= {15'h0000, aux_clk, main_clk, bus_addr_q, waking, frame_err_q,
                     state_q == osc_serial_pkg::ST_SHIFT, bit_cnt_q};
        end else if (haddr == `OFS_COMMITS) begin
          hrdata <= {16'h0000, commit_cnt_q};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_q <= `CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == `OFS_CTRL) begin
      ctrl_en_q <= hwdata[`CTRL_PORT_EN];
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_commit_word;
    @(posedge hclk) disable iff (!hresetn)
    commit |=> setting_q == $past(shift_q);
  endproperty
  a_commit_word: assert property (p_commit_word) else $error("word not committed");
  property p_short_frame;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == osc_serial_pkg::ST_SHIFT && sen_rise && bit_cnt_q != `WORD_BITS)
      |=> $stable(setting_q) && frame_err_q;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("bad frame committed");
  property p_shift_rise;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == osc_serial_pkg::ST_SHIFT && sclk_rise && !sen_fall)
      |=> shift_q[0] == $past(sdi_s) && shift_q[15:1] == $past(shift_q[14:0]);
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("bit not shifted");
  property p_no_shift_fall;
    @(posedge hclk) disable iff (!hresetn)
    !sclk_rise |=> $stable(shift_q);
  endproperty
  a_no_shift_fall: assert property (p_no_shift_fall) else $error("shift off edge");
  property p_start;
    @(posedge hclk) disable iff (!hresetn)
    (sen_fall && ctrl_en_q) |=> state_q == osc_serial_pkg::ST_SHIFT && bit_cnt_q == 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("transaction not started");
  property p_gate;
    @(posedge hclk) disable iff (!hresetn)
    !output_gate |-> !main_clk && !aux_clk;
  endproperty
  a_gate: assert property (p_gate) else $error("outputs not gated");
  property p_reset_setting;
    @(posedge hclk) disable iff (!hresetn)
    commit_cnt_q == 16'h0000 |-> setting_q == 16'h0000 && !waking;
  endproperty
  a_reset_setting: assert property (p_reset_setting) else $error("setting not zero");
  property p_strap;
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> bus_addr_q == {ADDR_BASE, $past(strap_s)};
  endproperty
  a_strap: assert property (p_strap) else $error("address strap wrong");
  property p_toggle_src;
    @(posedge hclk) disable iff (!hresetn)
    $changed(phase_q) |-> $past(half_cnt_q) == 27'h0;
  endproperty
  a_toggle_src: assert property (p_toggle_src) else $error("phase toggled early");
  property p_wake_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (cfg != `CFG_SHUTDOWN && $past(cfg) == `CFG_SHUTDOWN) |-> (!main_clk && !aux_clk) [*8];
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("output during wake");
  property p_aux_only;
    @(posedge hclk) disable iff (!hresetn)
    ($past(cfg) == `CFG_AUX_ONLY && cfg == `CFG_AUX_ONLY) |-> !main_clk;
  endproperty
  a_aux_only: assert property (p_aux_only) else $error("main runs in aux mode");

  c_commit: cover property (@(posedge hclk) disable iff (!hresetn) commit);
  c_frame_err: cover property (@(posedge hclk) disable iff (!hresetn) $rose(frame_err_q));
  c_shutdown: cover property (@(posedge hclk) disable iff (!hresetn) $fell(waking));
  c_gate: cover property (@(posedge hclk) disable iff (!hresetn) $fell(output_gate));
endmodule
`default_nettype wire

//--- rtl/osc_serial_regs.svh
// Register map, field layout and timing constants of the oscillator serial programming port
//
// Functional notes
// - The serial data input is the only source of the programming word.
// - Serial data shifts in on each serial clock rising edge; falling edges ignored.
// - Port enable falling edge starts a new transaction.
// - Port enable rising after exactly 16 clocks commits the shifted word.
// - In the two-wire variant a strap input selects the device's bus address.
// - Output gate low forces main and auxiliary outputs low asynchronously.
// - Output frequency derives only from the serially loaded setting.
// - At reset every setting bit is zero: lowest frequency, both outputs running.
// - Word holds a 4-bit octave code on top, 10-bit fine-tune below.
// - Config 00 complementary, 01 aux only, 10 main only, 11 shutdown.
`ifndef OSC_SERIAL_REGS_SVH
`define OSC_SERIAL_REGS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_SETTING   8'h04
`define OFS_STATUS    8'h08
`define OFS_COMMITS   8'h0c

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define CTRL_PORT_EN      0
`define CTRL_RESET        1'h1
`define ST_CNT_LO         0
`define ST_CNT_HI         4
`define ST_BUSY           5
`define ST_FRAME_ERR      6
`define ST_WAKING         7
`define ST_ADDR_LO        8
`define ST_ADDR_HI        14
`define ST_MAIN           15
`define ST_AUX            16
`define OCT_HI            15
`define OCT_LO            12
`define DAC_HI            11
`define DAC_LO            2
`define CNF_HI_BIT        1
`define CNF_LO_BIT        0

// -----------------------------------------------------------------
// Values and timing
// -----------------------------------------------------------------
`define SETTING_RESET     16'h0000
`define WORD_BITS         5'h10
`define CNT_MAX           5'h1f
`define CFG_SHUTDOWN      2'h3
`define CFG_AUX_ONLY      2'h1
`define CFG_MAIN_ONLY     2'h2
`define FULL_SCALE        12'h800
`define OCT_MAX           5'h0f
`define CLK_MHZ           20
`define WAKE_TIME_US      100
`define WAKE_CYCLES       (`WAKE_TIME_US * `CLK_MHZ)

`endif

//--- rtl/pin_sync.sv
// Two-flop synchroniser for pins arriving from outside the bus clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule
`default_nettype wire
